// file: bcs_defs.vh
// Purpose: shared constants for the block copy / search engine
// Assumes: one clock state equals one mclk cycle
// Notes:   definitions only
`ifndef BCS_DEFS_VH
`define BCS_DEFS_VH

// command encoding fields
`define BCS_OP_DOWN     0
`define BCS_OP_REPEAT   1
`define BCS_OP_SEARCH   2

// commands: {search, repeat, down}
`define BCS_CMD_COPY_STEP_UP       3'h0
`define BCS_CMD_COPY_STEP_DOWN     3'h1
`define BCS_CMD_COPY_REPEAT_UP     3'h2
`define BCS_CMD_COPY_REPEAT_DOWN   3'h3
`define BCS_CMD_SEARCH_STEP_UP     3'h4
`define BCS_CMD_SEARCH_STEP_DOWN   3'h5
`define BCS_CMD_SEARCH_REPEAT_UP   3'h6
`define BCS_CMD_SEARCH_REPEAT_DOWN 3'h7

// step timing in clock states and machine cycles
`define BCS_STATES_FINAL    5'd16
`define BCS_STATES_REPEAT   5'd21
`define BCS_MCYC_FINAL      3'd4
`define BCS_MCYC_REPEAT     3'd5

// clock-state slots inside a step
`define BCS_T_READ      5'd3
`define BCS_T_DATA      5'd5
`define BCS_T_PUSH      5'd6
`define BCS_T_LAUNCH    5'd7
`define BCS_T_WRITE     5'd8

// flag byte bit positions
`define BCS_F_SIGN      7
`define BCS_F_ZERO      6
`define BCS_F_HALF      4
`define BCS_F_PV        2
`define BCS_F_SUBTRACT  1
`define BCS_F_CARRY     0

// arithmetic / logic operation codes
`define BCS_ALU_ADD     3'h0
`define BCS_ALU_ADC     3'h1
`define BCS_ALU_SUB     3'h2
`define BCS_ALU_SBC     3'h3
`define BCS_ALU_AND     3'h4
`define BCS_ALU_XOR     3'h5
`define BCS_ALU_OR      3'h6
`define BCS_ALU_CMP     3'h7

// flag reset value and buffer depth
`define BCS_FLAGS_RST   8'h00
`define BCS_FIFO_DEPTH  16
`endif

// file: bcs_fifo.v
// Purpose: byte buffer between memory read and memory write
// Assumes: synchronous active-low reset
// Notes:   full and empty come from an occupancy counter
`timescale 1ns/1ns
module bcs_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// clock and reset
	input  wire             mclk,
	input  wire             rst_n,
	// fill side
	input  wire             inValid,
	output wire             inReady,
	input  wire [WIDTH-1:0] inData,
	// drain side
	output wire             outValid,
	input  wire             outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wrPtr_q;
	reg [AW-1:0]    rdPtr_q;
	reg [AW:0]      level_q;
	wire            doPush;
	wire            doPop;

	// handshakes; ready drops honestly when full
	assign inReady  = (level_q != DEPTH[AW:0]);
	assign outValid = (level_q != {(AW+1){1'b0}});
	assign outData  = mem[rdPtr_q];
	assign doPush   = inValid & inReady;
	assign doPop    = outValid & outReady;

	// storage array has no reset, only pointers and occupancy do
	always @(posedge mclk) begin
		if (doPush) begin
			mem[wrPtr_q] <= inData;
		end
	end

	// pointers and occupancy
	always @(posedge mclk) begin
		if (!rst_n) begin
			wrPtr_q <= {AW{1'b0}};
			rdPtr_q <= {AW{1'b0}};
			level_q <= {(AW+1){1'b0}};
		end else begin
			if (doPush) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (doPop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
			if (doPush & ~doPop) begin
				level_q <= level_q + 1'b1;
			end else if (doPop & ~doPush) begin
				level_q <= level_q - 1'b1;
			end
		end
	end
endmodule // bcs_fifo

// file: bcs_alu8.v
// Purpose: 8-bit arithmetic and logic unit with flag results
// Assumes: purely combinational
// Notes:   undocumented flag bits pass through from flagsIn
`timescale 1ns/1ns
`include "bcs_defs.vh"
module bcs_alu8 (
	// operation
	input  wire [2:0] op,
	input  wire [7:0] opA,
	input  wire [7:0] opB,
	input  wire [7:0] flagsIn,
	// results
	output reg  [7:0] result,
	output reg  [7:0] flagsOut
);
	reg       isSub;
	reg       cin;
	reg [8:0] full;
	reg [4:0] half;
	reg       ovf;

	// one adder serves add and subtract; compare discards the result
	always @* begin
		isSub    = (op == `BCS_ALU_SUB) | (op == `BCS_ALU_SBC) | (op == `BCS_ALU_CMP);
		cin      = ((op == `BCS_ALU_ADC) | (op == `BCS_ALU_SBC)) & flagsIn[`BCS_F_CARRY];
		if (isSub) begin
			full = {1'b0, opA} - {1'b0, opB} - {8'h00, cin};
			half = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, cin};
			ovf  = (opA[7] != opB[7]) && (full[7] != opA[7]);
		end else begin
			full = {1'b0, opA} + {1'b0, opB} + {8'h00, cin};
			half = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
			ovf  = (opA[7] == opB[7]) && (full[7] != opA[7]);
		end
		flagsOut = flagsIn;
		case (op)
		`BCS_ALU_AND: result = opA & opB;
		`BCS_ALU_XOR: result = opA ^ opB;
		`BCS_ALU_OR:  result = opA | opB;
		default:      result = full[7:0];
		endcase
		flagsOut[`BCS_F_SIGN] = result[7];
		flagsOut[`BCS_F_ZERO] = (result == 8'h00);
		flagsOut[`BCS_F_SUBTRACT] = isSub;
		if (op[2] && op != `BCS_ALU_CMP) begin
			flagsOut[`BCS_F_HALF]  = (op == `BCS_ALU_AND);
			flagsOut[`BCS_F_PV]    = ~^result;   // even count of ones
			flagsOut[`BCS_F_CARRY] = 1'b0;
		end else begin
			flagsOut[`BCS_F_HALF]  = half[4];
			flagsOut[`BCS_F_PV]    = ovf;        // signed overflow
			flagsOut[`BCS_F_CARRY] = full[8];
		end
		if (op == `BCS_ALU_CMP) begin
			result = opA;                        // compare leaves accumulator
		end
	end
endmodule // bcs_alu8

// file: bcs_copy_search.v
// Purpose: block copy / block search engine plus 8-bit flag unit
// Assumes: memory drives read data in the cycle after the read pulse
// Notes:   one clock state per mclk cycle; only memory wait states
//          stretch a step beyond 16 or 21 states
// Contract
// - single copy: move byte, step pointers, 16 states
// - repeat copy: 21 states per step, 16 last
// - parity/overflow flag clear when counter reaches zero
// - search compares accumulator, zero flag on match
// - repeat search continues: 21 states per step
// - repeat search ends on zero or match, 16
// - arithmetic overflow sets parity/overflow flag
// - logical even parity sets parity/overflow flag
`timescale 1ns/1ns
`include "bcs_defs.vh"
module bcs_copy_search (
	// clock and reset
	input  wire        mclk,
	input  wire        rst_n,
	// block command
	input  wire        cmdValid,
	output wire        cmdReady,
	input  wire [2:0]  cmdOp,
	input  wire [15:0] cmdSourcePointer,
	input  wire [15:0] cmdDestPointer,
	input  wire [15:0] cmdByteCounter,
	input  wire [7:0]  cmdAccumulator,
	// standalone arithmetic request
	input  wire        aluGo,
	input  wire [2:0]  aluOp,
	input  wire [7:0]  aluA,
	input  wire [7:0]  aluB,
	output reg  [7:0]  aluResult,
	// flags load
	input  wire        flagsLoad,
	input  wire [7:0]  flagsLoadValue,
	// memory port
	output reg         memRdEn,
	output reg         memWrEn,
	output reg  [15:0] memAddr,
	output reg  [7:0]  memWdata,
	input  wire [7:0]  memRdata,
	input  wire        memWrReady,
	// status
	output wire        busy,
	output reg         donePulse,
	output reg  [15:0] sourcePointer,
	output reg  [15:0] destPointer,
	output reg  [15:0] byteCounter,
	output reg  [7:0]  flags,
	output reg  [4:0]  stateCount,
	output reg  [2:0]  machineCycles
);
	// one-hot engine states
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_RUN  = 2'b10;

	reg  [1:0]  state_q;
	reg  [2:0]  op_q;
	reg  [7:0]  acc_q;
	reg  [7:0]  byte_q;
	reg         push_q;
	reg         wrDone_q;
	reg         match_q;
	wire        isSearch;
	wire        isRepeat;
	wire        isDown;
	wire [15:0] cntNext;
	wire        lastStep;
	wire [4:0]  stepLen;
	wire        atEnd;
	wire        stall;
	wire        fifoInReady;
	wire        fifoOutValid;
	wire        fifoOutReady;
	wire [7:0]  fifoOutData;
	wire [2:0]  aluSelOp;
	wire [7:0]  aluSelA;
	wire [7:0]  aluSelB;
	wire [7:0]  aluRes;
	wire [7:0]  aluFlags;

	// command decode
	assign isSearch = op_q[`BCS_OP_SEARCH];
	assign isRepeat = op_q[`BCS_OP_REPEAT];
	assign isDown   = op_q[`BCS_OP_DOWN];
	assign cmdReady = state_q[0];
	assign busy     = state_q[1];
	assign cntNext  = byteCounter - 16'h0001;

	// step length is fixed once the compare result exists, well before it is needed
	assign lastStep = ~isRepeat | (cntNext == 16'h0000) | (isSearch & match_q);
	assign stepLen  = lastStep ? `BCS_STATES_FINAL : `BCS_STATES_REPEAT;
	assign atEnd    = state_q[1] && (stateCount == stepLen - 5'd1);

	// the state counter freezes only while the buffer is full or the memory
	// holds off the write; a zero-wait memory keeps every step at its nominal
	// 16 or 21 states, so the only stretch a user sees is the memory's own wait
	assign stall = state_q[1] &&
		((stateCount == `BCS_T_PUSH && push_q && !fifoInReady) ||
		 (stateCount == `BCS_T_WRITE && !isSearch && !wrDone_q &&
		  !(memWrEn && memWrReady)));

	// the launch slot drains one byte from the buffer into a write request, one
	// state ahead of the write slot, so that an immediate acknowledge lands
	// inside the write slot instead of after it
	assign fifoOutReady = state_q[1] && stateCount == `BCS_T_LAUNCH && !isSearch
		&& !memWrEn && !wrDone_q;

	// byte buffer in the copy path; full stalls the read side
	bcs_fifo #(
		.WIDTH (8),
		.DEPTH (`BCS_FIFO_DEPTH),
		.AW    (4)
	) u_fifo (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.inValid  (push_q),
		.inReady  (fifoInReady),
		.inData   (byte_q),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOutData)
	);

	// the flag unit serves the search compare while busy, requests otherwise
	assign aluSelOp = state_q[1] ? `BCS_ALU_CMP : aluOp;
	assign aluSelA  = state_q[1] ? acc_q : aluA;
	assign aluSelB  = state_q[1] ? byte_q : aluB;

	bcs_alu8 u_alu (
		.op       (aluSelOp),
		.opA      (aluSelA),
		.opB      (aluSelB),
		.flagsIn  (flags),
		.result   (aluRes),
		.flagsOut (aluFlags)
	);

	// step timeline in clock states (one per mclk):
	//   3  read pulse is launched at the source address
	//   4  read pulse on the bus, memory answers in the next state
	//   5  read byte captured
	//   6  byte pushed into the buffer, search compare captured
	//   7  buffered byte launched as a write to the destination
	//   8  write held here until the memory accepts it
	//   15 or 20  pointers, counter and flags step; the step ends
	// read and write never share a state, so one address register serves both
	// state machine and clock-state counter
	always @(posedge mclk) begin
		if (!rst_n) begin
			state_q       <= ST_IDLE;
			stateCount    <= 5'd0;
			machineCycles <= 3'd0;
			donePulse     <= 1'b0;
			op_q          <= 3'h0;
			acc_q         <= 8'h00;
		end else begin
			donePulse <= 1'b0;
			case (state_q)
			ST_IDLE: begin
				stateCount <= 5'd0;
				if (cmdValid) begin
					state_q <= ST_RUN;
					op_q    <= cmdOp;
					acc_q   <= cmdAccumulator;
				end
			end
			ST_RUN: begin
				if (atEnd) begin
					stateCount    <= 5'd0;
					machineCycles <= lastStep ? `BCS_MCYC_FINAL : `BCS_MCYC_REPEAT;
					if (lastStep) begin
						state_q   <= ST_IDLE;
						donePulse <= 1'b1;
					end
				end else if (!stall) begin
					stateCount <= stateCount + 5'd1;
				end
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end

	// memory read, capture and buffer push; push_q stays up while the buffer
	// is full, which holds the counter in the push slot
	always @(posedge mclk) begin
		if (!rst_n) begin
			memRdEn <= 1'b0;
			byte_q  <= 8'h00;
			push_q  <= 1'b0;
			match_q <= 1'b0;
		end else begin
			memRdEn <= 1'b0;
			if (state_q[1] && stateCount == `BCS_T_READ && !stall) begin
				memRdEn <= 1'b1;
			end
			if (state_q[1] && stateCount == `BCS_T_DATA) begin
				byte_q <= memRdata;
				push_q <= ~isSearch;
			end else if (push_q && fifoInReady) begin
				push_q <= 1'b0;
			end
			if (state_q[0]) begin
				match_q <= 1'b0;
			end else if (stateCount == `BCS_T_PUSH) begin
				match_q <= (acc_q == byte_q);
			end
		end
	end

	// memory write request held until the memory accepts it; wrDone_q keeps
	// the launch slot from issuing a second write in the same step
	always @(posedge mclk) begin
		if (!rst_n) begin
			memWrEn  <= 1'b0;
			memWdata <= 8'h00;
			wrDone_q <= 1'b0;
		end else begin
			if (fifoOutReady && fifoOutValid) begin
				memWrEn  <= 1'b1;
				memWdata <= fifoOutData;
			end else if (memWrEn && memWrReady) begin
				memWrEn  <= 1'b0;
				wrDone_q <= 1'b1;
			end
			if (atEnd) begin
				wrDone_q <= 1'b0;
			end
		end
	end

	// address mux: source for the read slot, destination for writes
	always @(posedge mclk) begin
		if (!rst_n) begin
			memAddr <= 16'h0000;
		end else if (state_q[1] && stateCount == `BCS_T_READ) begin
			memAddr <= sourcePointer;
		end else if (fifoOutReady && fifoOutValid) begin
			memAddr <= destPointer;
		end
	end

	// pointers and counter: load on command, step at the end of each step;
	// a count loaded as zero wraps to ffff, so a repeat started at zero runs
	// through the whole 64k range before it stops, unless a search finds a match first
	always @(posedge mclk) begin
		if (!rst_n) begin
			sourcePointer <= 16'h0000;
			destPointer   <= 16'h0000;
			byteCounter   <= 16'h0000;
		end else if (state_q[0] && cmdValid) begin
			sourcePointer <= cmdSourcePointer;
			destPointer   <= cmdDestPointer;
			byteCounter   <= cmdByteCounter;
		end else if (atEnd) begin
			byteCounter <= cntNext;
			if (isDown) begin
				sourcePointer <= sourcePointer - 16'h0001;
			end else begin
				sourcePointer <= sourcePointer + 16'h0001;
			end
			if (!isSearch) begin
				if (isDown) begin
					destPointer <= destPointer - 16'h0001;
				end else begin
					destPointer <= destPointer + 16'h0001;
				end
			end
		end
	end

	// flag byte: step results, standalone operations, or a direct load;
	// block steps leave carry and the two spare bits alone, and a step end
	// outranks any request because requests are refused while busy
	always @(posedge mclk) begin
		if (!rst_n) begin
			flags     <= `BCS_FLAGS_RST;
			aluResult <= 8'h00;
		end else if (atEnd) begin
			flags[`BCS_F_PV] <= (cntNext != 16'h0000);
			if (isSearch) begin
				flags[`BCS_F_SIGN]     <= aluFlags[`BCS_F_SIGN];
				flags[`BCS_F_ZERO]     <= aluFlags[`BCS_F_ZERO];
				flags[`BCS_F_HALF]     <= aluFlags[`BCS_F_HALF];
				flags[`BCS_F_SUBTRACT] <= 1'b1;
			end else begin
				flags[`BCS_F_HALF]     <= 1'b0;
				flags[`BCS_F_SUBTRACT] <= 1'b0;
			end
		end else if (state_q[0] && aluGo) begin
			flags     <= aluFlags;
			aluResult <= aluRes;
		end else if (state_q[0] && flagsLoad) begin
			flags <= flagsLoadValue;
		end
	end
endmodule // bcs_copy_search

// file: bcs_cs_monitor.sv
// Purpose: port-level checks of the block copy / search engine
// Assumes: one clock state per mclk cycle, synchronous active-low reset
// Notes:   bound to every instance of the engine
`timescale 1ns/1ns
module bcs_cs_monitor (
	// clock, reset and command
	input wire        mclk,
	input wire        rst_n,
	input wire        cmdValid,
	input wire        cmdReady,
	// memory port
	input wire        memRdEn,
	input wire        memWrEn,
	input wire [15:0] memAddr,
	input wire [7:0]  memWdata,
	input wire        memWrReady,
	// status
	input wire        busy,
	input wire        donePulse,
	input wire [15:0] sourcePointer,
	input wire [15:0] destPointer,
	input wire [15:0] byteCounter,
	input wire [7:0]  flags,
	input wire [4:0]  stateCount,
	input wire [2:0]  machineCycles
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// a stalled write must not move its address or data under the memory
	sequence wrStall;
		memWrEn && !memWrReady;
	endsequence
	sequence wrHeld;
		memWrEn && $stable(memAddr) && $stable(memWdata);
	endsequence
	start_busy_a: assert property (cmdValid && cmdReady |=> busy)
		else $error("command taken but engine stayed idle");
	read_slot_a: assert property (memRdEn |-> stateCount == 5'h4 && memAddr == sourcePointer)
		else $error("read outside its slot or not at the source");
	write_hold_a: assert property (wrStall |=> wrHeld)
		else $error("stalled write dropped or changed");
	write_addr_a: assert property (memWrEn |-> memAddr == destPointer)
		else $error("write not at the destination");
	write_slot_a: assert property (memWrEn |-> stateCount == 5'h8)
		else $error("write outside its slot");
	pv_done_a: assert property (donePulse |-> flags[2] == (byteCounter != 16'h0))
		else $error("parity/overflow flag disagrees with counter");
	final_cycles_a: assert property (donePulse |-> machineCycles == 3'h4)
		else $error("last step not four machine cycles");
	repeat_cycles_a: assert property (busy && stateCount == 5'h14 |=> machineCycles == 3'h5)
		else $error("repeating step not five machine cycles");
	source_step_a: assert property ($past(busy) && $changed(sourcePointer)
		|-> sourcePointer == $past(sourcePointer) + 16'h1
		|| sourcePointer == $past(sourcePointer) - 16'h1)
		else $error("source pointer moved by more than one");
	count_step_a: assert property ($past(busy) && $changed(byteCounter)
		|-> byteCounter == $past(byteCounter) - 16'h1)
		else $error("byte counter not decremented by one");
endmodule // bcs_cs_monitor

bind bcs_copy_search bcs_cs_monitor uMon (.mclk, .rst_n, .cmdValid, .cmdReady, .memRdEn,
	.memWrEn, .memAddr, .memWdata, .memWrReady, .busy, .donePulse, .sourcePointer,
	.destPointer, .byteCounter, .flags, .stateCount, .machineCycles);

// file: bcs_mem_model.sv
// Purpose: byte memory on the far side of the engine's memory port
// Assumes: read data is wanted only in the cycle after the read pulse
// Notes:   write latency set by wrLat, 0 acks in the cycle the write rises
`timescale 1ns/1ns
module bcs_mem_model (
	// clock and request
	input  wire        mclk,
	input  wire        memRdEn,
	input  wire        memWrEn,
	input  wire [15:0] memAddr,
	input  wire [7:0]  memWdata,
	input  wire [2:0]  wrLat,
	// answers
	output reg  [7:0]  memRdata,
	output wire        memWrReady
);
	logic [7:0] mem [0:255];
	logic [2:0] waitCnt_q = 3'h0;
	initial memRdata = 8'h5a;
	// ack once the write has waited wrLat cycles
	assign memWrReady = memWrEn && (waitCnt_q >= wrLat);
	// data toggles outside the valid cycle so a late sample cannot pass by luck
	always @(posedge mclk) begin
		memRdata <= memRdEn ? mem[memAddr[7:0]] : ~memRdata;
		waitCnt_q <= (memWrEn && !memWrReady) ? waitCnt_q + 3'h1 : 3'h0;
		if (memWrEn && memWrReady)
			mem[memAddr[7:0]] <= memWdata;
	end
endmodule // bcs_mem_model

// file: test_bcs_copy_search.sv
// Purpose: self-checking bench for the block copy / search engine
// Assumes: inputs change 1 ns after the rising edge
// Notes:   memory holds i^a5 below 8'h40 and zero above
`timescale 1ns/1ns
module test_bcs_copy_search;
	// stimulus
	logic        mclk = 0, rst_n = 0, cmdValid = 0, aluGo = 0, flagsLoad = 0;
	logic [2:0]  cmdOp = 0, aluOp = 0, wrLat = 0;
	logic [15:0] cmdSourcePointer = 0, cmdDestPointer = 0, cmdByteCounter = 0;
	logic [7:0]  cmdAccumulator = 0, aluA = 0, aluB = 0, flagsLoadValue = 0;
	// design outputs
	wire         cmdReady, memRdEn, memWrEn, memWrReady, busy, donePulse;
	wire  [15:0] memAddr, sourcePointer, destPointer, byteCounter;
	wire  [7:0]  memWdata, memRdata, aluResult, flags;
	wire  [4:0]  stateCount;
	wire  [2:0]  machineCycles;
	int          n_mismatch = 0, tests_run = 0;

	bcs_copy_search DUT (.mclk, .rst_n, .cmdValid, .cmdReady, .cmdOp, .cmdSourcePointer,
		.cmdDestPointer, .cmdByteCounter, .cmdAccumulator, .aluGo, .aluOp, .aluA, .aluB,
		.aluResult, .flagsLoad, .flagsLoadValue, .memRdEn, .memWrEn, .memAddr, .memWdata,
		.memRdata, .memWrReady, .busy, .donePulse, .sourcePointer, .destPointer,
		.byteCounter, .flags, .stateCount, .machineCycles);
	bcs_mem_model MEM (.mclk, .memRdEn, .memWrEn, .memAddr, .memWdata, .wrLat, .memRdata,
		.memWrReady);

	initial begin
		forever #4 mclk = ~mclk;
	end

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [7:0] at(input logic [15:0] a);
		return MEM.mem[a[7:0]];
	endfunction

	// one command from take to done; cyc counts busy cycles
	task automatic run(input logic [2:0] op, input logic [15:0] s, d, n,
		input logic [7:0] acc, output int cyc);
		int k;
		@(posedge mclk) #1;
		{cmdOp, cmdSourcePointer, cmdDestPointer, cmdByteCounter} = {op, s, d, n};
		cmdAccumulator = acc;
		cmdValid = 1;
		@(posedge mclk) #1;
		cmdValid = 0;
		cyc = 0;
		for (k = 0; k < 3000 && donePulse !== 1'b1; k++) begin
			cyc += busy;
			@(posedge mclk) #1;
		end
		check(donePulse, 1'b1);
	endtask

	// copy: every byte lands, the byte past the block stays untouched
	task automatic copy_case(input logic [2:0] op, input logic [15:0] s, n,
		input logic [2:0] lat);
		int cyc, i;
		logic [15:0] dir, d, st;
		dir = op[0] ? 16'hffff : 16'h0001;
		d = s + 16'h0040;
		st = op[1] ? n : 16'h0001;
		wrLat = lat;
		run(op, s, d, n, 8'h00, cyc);
		check(16'(cyc), 16'(21 * st - 5 + lat * st));
		for (i = 0; i < st; i++)
			check(at(d + dir * i), at(s + dir * i));
		check(at(d + dir * st), 8'h00);
		check(sourcePointer, s + dir * st);
		check(destPointer, d + dir * st);
		check(byteCounter, n - st);
		check(flags[2], n != st);
		check(machineCycles, 3'h4);
	endtask

	// search: exact step timing, zero flag from the compare
	task automatic search_case(input logic [2:0] op, input logic [15:0] s, n,
		input logic [7:0] acc, input logic [15:0] st, input logic z);
		int cyc;
		logic [15:0] dir;
		dir = op[0] ? 16'hffff : 16'h0001;
		run(op, s, 16'h0000, n, acc, cyc);
		check(16'(cyc), 16'(21 * st - 5));
		check(flags[6], z);
		check(flags[2], n != st);
		check(sourcePointer, s + dir * st);
		check(byteCounter, n - st);
	endtask

	// standalone arithmetic with a loaded carry
	task automatic alu_case(input logic [2:0] op, input logic [7:0] a, b, input logic cin,
		input logic [7:0] res, input logic pv);
		@(posedge mclk) #1;
		flagsLoad = 1;
		flagsLoadValue = {7'h0, cin};
		@(posedge mclk) #1;
		flagsLoad = 0;
		check(flags, {7'h0, cin});
		{aluOp, aluA, aluB} = {op, a, b};
		aluGo = 1;
		@(posedge mclk) #1;
		aluGo = 0;
		check(aluResult, res);
		check(flags[2], pv);
	endtask

	// watchdog well past the few hundred cycles the tests need
	initial begin
		#100000;
		n_mismatch++;
		end_of_test();
	end

	initial begin
		for (int i = 0; i < 256; i++)
			MEM.mem[i] = (i < 64) ? 8'(i) ^ 8'ha5 : 8'h00;
		repeat (12) @(posedge mclk);
		#1 rst_n = 1;
		check(cmdReady, 1'b1);
		check(busy, 1'b0);
		check(flags, 8'h00);
		copy_case(3'h0, 16'h0020, 16'h0005, 3'h0);
		copy_case(3'h1, 16'h0038, 16'h0000, 3'h1);
		copy_case(3'h2, 16'h0010, 16'h0003, 3'h0);
		copy_case(3'h3, 16'h0030, 16'h0004, 3'h3);
		search_case(3'h4, 16'h0021, 16'h0002, 8'h84, 16'h0001, 1'b1);
		search_case(3'h5, 16'h0020, 16'h0001, 8'h00, 16'h0001, 1'b0);
		search_case(3'h6, 16'h0010, 16'h0005, 8'hb7, 16'h0003, 1'b1);
		search_case(3'h7, 16'h0030, 16'h0003, 8'h00, 16'h0003, 1'b0);
		alu_case(3'h0, 8'h7f, 8'h01, 1'b0, 8'h80, 1'b1);
		alu_case(3'h0, 8'h01, 8'h01, 1'b0, 8'h02, 1'b0);
		alu_case(3'h1, 8'h7f, 8'h00, 1'b1, 8'h80, 1'b1);
		alu_case(3'h2, 8'h80, 8'h01, 1'b0, 8'h7f, 1'b1);
		alu_case(3'h3, 8'h00, 8'h00, 1'b1, 8'hff, 1'b0);
		alu_case(3'h4, 8'hf0, 8'h0f, 1'b0, 8'h00, 1'b1);
		alu_case(3'h5, 8'h01, 8'h00, 1'b0, 8'h01, 1'b0);
		alu_case(3'h6, 8'h03, 8'h00, 1'b0, 8'h03, 1'b1);
		alu_case(3'h7, 8'h7f, 8'hff, 1'b0, 8'h7f, 1'b1);
		end_of_test();
	end
endmodule // test_bcs_copy_search
